// *** pfap_pkg.sv ***
// constants, types and register layout of the program flash access and protection block
package pfap_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned PROG_TIME_NS    = 5000;
  localparam int unsigned PROG_CYCLES     = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0]  FLASH_CTRL_STAT_OFS   = 8'h2F;
  localparam logic [7:0]  FLASH_CTRL_STAT_RESET = 8'h00;
  localparam int unsigned OPTION_AREA_SEL_POS   = 2;
  localparam int unsigned LATCH_ENABLE_POS      = 1;
  localparam int unsigned PROGRAM_START_POS     = 0;

  localparam logic [7:0]  UNLOCK_KEY_FIRST  = 8'h56;
  localparam logic [7:0]  UNLOCK_KEY_SECOND = 8'hAE;

  localparam logic [5:0]  ENTRY_PULSES_EXT = 6'h23;
  localparam logic [5:0]  ENTRY_PULSES_RC  = 6'h26;

  localparam logic [7:0]  OPTION_BYTE_RESET  = 8'h00;
  localparam int unsigned READ_PROTECT_POS   = 0;
  localparam int unsigned WRITE_PROTECT_POS  = 1;

  localparam int unsigned LATCH_BYTES = 32;
  localparam int unsigned ADDR_W      = 11;
  localparam int unsigned IDX_W       = 5;
  localparam int unsigned ROW_W       = ADDR_W - IDX_W;
  localparam logic [IDX_W-1:0] LAST_IDX = 5'h1F;

  typedef enum logic [4:0] {
    PFAP_IDLE  = 5'h01,
    PFAP_MASS  = 5'h02,
    PFAP_ERASE = 5'h04,
    PFAP_PROG  = 5'h08,
    PFAP_WAIT  = 5'h10
  } pfap_seq_t;

  typedef enum logic [2:0] {
    PFAP_LOCKED = 3'h1,
    PFAP_HALF   = 3'h2,
    PFAP_OPEN   = 3'h4
  } pfap_unlock_t;

  typedef struct packed {
    logic              wr;
    logic              erase_sector;
    logic              erase_all;
    logic              optb_wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } pfap_flash_cmd_t;

endpackage

// *** pfap_sync.sv ***
// two-flop synchroniser for pin inputs
module pfap_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // per-bit reset level avoids a false edge when the pin idles high
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

// *** pfap_timer.sv ***
// one-shot cycle timer for programming and erase durations
module pfap_timer #(
  parameter int unsigned CNT_W  = 8,
  parameter int unsigned CYCLES = 100
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_ff <= LOAD;
        busy   <= 1'b1;
      end else if (busy) begin
        if (cnt_ff == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
      end
    end
  end

endmodule

// *** pfap_top.sv ***
// program flash sequencer with unlock keys, protection options and serial mode entry
module pfap_top
  import pfap_pkg::*;
#(
  parameter logic [ADDR_W-1:0] SECTOR0_BYTES = 11'h400
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [7:0]        REG_RDATA,
  input  wire logic              MEM_WR,
  input  wire logic [ADDR_W-1:0] MEM_ADDR,
  input  wire logic [7:0]        MEM_WDATA,
  output pfap_flash_cmd_t        FLASH_CMD,
  output logic                   FLASH_REFUSED,
  output logic      [7:0]        OPTION_BYTE,
  input  wire logic              RESET_PIN_N,
  input  wire logic              SERIAL_LINK_CLOCK_PIN_I,
  output logic                   SERIAL_LINK_CLOCK_PIN_O,
  output logic                   SERIAL_LINK_CLOCK_PIN_OE_N,
  output logic                   SERIAL_LINK_CLOCK_PULLUP_EN,
  input  wire logic              APP_CLK_PIN_OUT_EN,
  input  wire logic              APP_CLK_PIN_LEVEL,
  output logic                   IN_CIRCUIT_COMM_MODE,
  output logic                   EXTERNAL_CLOCK_INPUT_SEL,
  output logic                   INTERNAL_RC_FORCED,
  output logic                   READOUT_BLOCK
);

  pfap_seq_t        state_ff;
  pfap_unlock_t     unlock_ff;
  logic             area_sel_ff;
  logic             latch_en_ff;
  logic             run_ff;
  logic             done_ff;
  logic             mass_done_ff;
  logic [IDX_W-1:0] idx_ff;
  logic [7:0]       latch_data_ff [LATCH_BYTES];
  logic [LATCH_BYTES-1:0] latch_vld_ff;
  logic [ROW_W-1:0] row_ff;
  logic [7:0]       optb_ff;
  logic [1:0]       pins_s;
  logic             rst_pin_s;
  logic             clk_pin_s;
  logic             rst_pin_q_ff;
  logic             clk_pin_q_ff;
  logic [5:0]       pulse_cnt_ff;
  logic             comm_ff;
  logic             tmr_busy;
  logic             tmr_done;

  // reset pin reads as held, clock pin as its pulled-up idle level
  pfap_sync #(.W(2), .RST_VAL(2'b01)) u_sync (
    .clk (REF_CLK),
    .rst (RST),
    .d   ({RESET_PIN_N, SERIAL_LINK_CLOCK_PIN_I}),
    .q   (pins_s)
  );

  assign rst_pin_s = pins_s[1];
  assign clk_pin_s = pins_s[0];

  wire fcs_hit  = (REG_ADDR == FLASH_CTRL_STAT_OFS);
  wire idle     = (state_ff == PFAP_IDLE);
  wire ctrl_wr  = REG_WR && fcs_hit && (unlock_ff == PFAP_OPEN) && idle && !run_ff;
  wire unlatch  = ctrl_wr && latch_en_ff && !REG_WDATA[LATCH_ENABLE_POS];
  wire start    = idle && run_ff && !done_ff;
  wire rp       = optb_ff[READ_PROTECT_POS];
  wire wp       = optb_ff[WRITE_PROTECT_POS];
  wire in_sec0  = ({row_ff, 5'h00} < SECTOR0_BYTES);
  wire area_ok  = latch_en_ff && latch_vld_ff[0];
  wire rp_clear = rp && !latch_data_ff[0][READ_PROTECT_POS];
  // protections checked independently, either one alone stops the array
  wire array_ok = !rp && !wp && (comm_ff || !in_sec0);
  wire go_mass  = start && area_sel_ff && area_ok && rp_clear;
  wire go_aprog = start && area_sel_ff && area_ok && !rp_clear;
  wire go_prog  = start && !area_sel_ff && latch_en_ff && array_ok;
  wire go_erase = start && !area_sel_ff && !latch_en_ff && array_ok;
  wire go_ref   = start && !(go_mass || go_aprog || go_prog || go_erase);
  wire prog_end = (state_ff == PFAP_PROG) && (area_sel_ff || idx_ff == LAST_IDX);
  wire tmr_go   = go_mass || go_erase || prog_end;

  pfap_timer #(.CNT_W(8), .CYCLES(PROG_CYCLES)) u_timer (
    .clk   (REF_CLK),
    .rst   (RST),
    .start (tmr_go),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // control register and unlock keys
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      unlock_ff   <= PFAP_LOCKED;
      area_sel_ff <= FLASH_CTRL_STAT_RESET[OPTION_AREA_SEL_POS];
      latch_en_ff <= FLASH_CTRL_STAT_RESET[LATCH_ENABLE_POS];
      run_ff      <= FLASH_CTRL_STAT_RESET[PROGRAM_START_POS];
    end else if (done_ff) begin
      latch_en_ff <= 1'b0;
      run_ff      <= 1'b0;
    end else if (REG_WR && fcs_hit) begin
      unique case (unlock_ff)
        PFAP_LOCKED: begin
          if (REG_WDATA == UNLOCK_KEY_FIRST) begin
            unlock_ff <= PFAP_HALF;
          end
        end
        PFAP_HALF: begin
          unlock_ff <= (REG_WDATA == UNLOCK_KEY_SECOND) ? PFAP_OPEN : PFAP_LOCKED;
        end
        PFAP_OPEN: begin
          if (ctrl_wr) begin
            area_sel_ff <= REG_WDATA[OPTION_AREA_SEL_POS];
            latch_en_ff <= REG_WDATA[LATCH_ENABLE_POS];
            run_ff      <= REG_WDATA[PROGRAM_START_POS];
          end
        end
      endcase
    end
  end

  // data latches; cleared at cycle end and when software drops the latch bit
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      latch_vld_ff <= '0;
      row_ff       <= '0;
      for (int i = 0; i < LATCH_BYTES; i++) begin
        latch_data_ff[i] <= 8'h00;
      end
    end else if (done_ff || unlatch) begin
      latch_vld_ff <= '0;
    end else if (MEM_WR && latch_en_ff && idle && !run_ff) begin
      // only the low five bits pick the byte; the row follows the last write
      latch_data_ff[MEM_ADDR[IDX_W-1:0]] <= MEM_WDATA;
      latch_vld_ff[MEM_ADDR[IDX_W-1:0]]  <= 1'b1;
      row_ff                             <= MEM_ADDR[ADDR_W-1:IDX_W];
    end
  end

  // sequencer
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_ff     <= PFAP_IDLE;
      idx_ff       <= '0;
      done_ff      <= 1'b0;
      mass_done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        PFAP_IDLE: begin
          idx_ff       <= '0;
          mass_done_ff <= 1'b0;
          if (go_mass) begin
            state_ff <= PFAP_MASS;
          end else if (go_aprog || go_prog) begin
            state_ff <= PFAP_PROG;
          end else if (go_erase) begin
            state_ff <= PFAP_ERASE;
          end else if (go_ref) begin
            done_ff <= 1'b1;
          end
        end
        PFAP_MASS: begin
          if (tmr_done) begin
            mass_done_ff <= 1'b1;
            state_ff     <= PFAP_PROG;
          end
        end
        PFAP_ERASE: begin
          if (tmr_done) begin
            state_ff <= PFAP_IDLE;
            done_ff  <= 1'b1;
          end
        end
        PFAP_PROG: begin
          idx_ff <= idx_ff + 1'b1;
          if (prog_end) begin
            state_ff <= PFAP_WAIT;
          end
        end
        PFAP_WAIT: begin
          if (tmr_done) begin
            state_ff <= PFAP_IDLE;
            done_ff  <= 1'b1;
          end
        end
      endcase
    end
  end

  // commands to the flash array, one byte per cycle while walking the latches
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FLASH_CMD     <= '0;
      FLASH_REFUSED <= 1'b0;
    end else begin
      FLASH_REFUSED          <= go_ref;
      FLASH_CMD.erase_all    <= go_mass;
      FLASH_CMD.erase_sector <= go_erase;
      FLASH_CMD.optb_wr      <= (state_ff == PFAP_PROG) && area_sel_ff;
      FLASH_CMD.wr           <= (state_ff == PFAP_PROG) && !area_sel_ff && latch_vld_ff[idx_ff];
      FLASH_CMD.addr         <= go_erase ? {row_ff, 5'h00} : {row_ff, idx_ff};
      FLASH_CMD.data         <= area_sel_ff ? latch_data_ff[0] : latch_data_ff[idx_ff];
    end
  end

  // option byte image; write protection can only ever be added
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      optb_ff <= OPTION_BYTE_RESET;
    end else if ((state_ff == PFAP_PROG) && area_sel_ff) begin
      optb_ff                    <= latch_data_ff[0];
      optb_ff[READ_PROTECT_POS]  <= latch_data_ff[0][READ_PROTECT_POS];
      optb_ff[WRITE_PROTECT_POS] <= wp | latch_data_ff[0][WRITE_PROTECT_POS];
    end
  end

  // serial mode entry: count clock pin pulses while the reset pin is low
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rst_pin_q_ff             <= 1'b0;
      clk_pin_q_ff             <= 1'b1;
      pulse_cnt_ff             <= '0;
      comm_ff                  <= 1'b0;
      EXTERNAL_CLOCK_INPUT_SEL <= 1'b0;
      INTERNAL_RC_FORCED       <= 1'b0;
    end else begin
      rst_pin_q_ff <= rst_pin_s;
      clk_pin_q_ff <= clk_pin_s;
      if (rst_pin_q_ff && !rst_pin_s) begin
        pulse_cnt_ff <= '0;
        comm_ff      <= 1'b0;
      end else if (!rst_pin_s && clk_pin_s && !clk_pin_q_ff && pulse_cnt_ff != 6'h3F) begin
        pulse_cnt_ff <= pulse_cnt_ff + 1'b1;
      end else if (!rst_pin_q_ff && rst_pin_s) begin
        comm_ff                  <= (pulse_cnt_ff == ENTRY_PULSES_EXT) ||
                                    (pulse_cnt_ff == ENTRY_PULSES_RC);
        EXTERNAL_CLOCK_INPUT_SEL <= (pulse_cnt_ff == ENTRY_PULSES_EXT);
        INTERNAL_RC_FORCED       <= (pulse_cnt_ff == ENTRY_PULSES_RC);
      end
    end
  end

  // status outputs and clock pin control; any reset drops the pin to pulled input
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SERIAL_LINK_CLOCK_PIN_OE_N  <= 1'b1;
      SERIAL_LINK_CLOCK_PIN_O     <= 1'b0;
      SERIAL_LINK_CLOCK_PULLUP_EN <= 1'b1;
      IN_CIRCUIT_COMM_MODE        <= 1'b0;
      READOUT_BLOCK               <= 1'b0;
      OPTION_BYTE                 <= OPTION_BYTE_RESET;
    end else begin
      SERIAL_LINK_CLOCK_PIN_OE_N  <= !(rst_pin_s && APP_CLK_PIN_OUT_EN);
      SERIAL_LINK_CLOCK_PIN_O     <= rst_pin_s && APP_CLK_PIN_LEVEL;
      SERIAL_LINK_CLOCK_PULLUP_EN <= !(rst_pin_s && APP_CLK_PIN_OUT_EN);
      IN_CIRCUIT_COMM_MODE        <= comm_ff;
      READOUT_BLOCK               <= comm_ff && rp;
      OPTION_BYTE                 <= optb_ff;
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD && fcs_hit) begin
      REG_RDATA <= {5'h00, area_sel_ff, latch_en_ff, run_ff};
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_rdata;
    REG_RD && fcs_hit |=> REG_RDATA == {5'h00, $past(area_sel_ff), $past(latch_en_ff), $past(run_ff)};
  endproperty
  a_rdata: assert property (p_rdata) else $error("control read data wrong");

  property p_unlock;
    $rose(run_ff) |-> $past(unlock_ff) == PFAP_OPEN;
  endproperty
  a_unlock: assert property (p_unlock) else $error("start taken while locked");

  property p_sec0;
    (FLASH_CMD.wr || FLASH_CMD.erase_sector) && !comm_ff |-> FLASH_CMD.addr >= SECTOR0_BYTES;
  endproperty
  a_sec0: assert property (p_sec0) else $error("sector 0 altered in application");

  property p_wp_sticky;
    wp |=> wp;
  endproperty
  a_wp_sticky: assert property (p_wp_sticky) else $error("write protection removed");

  property p_no_array;
    (rp || wp) |-> !FLASH_CMD.wr && !FLASH_CMD.erase_sector;
  endproperty
  a_no_array: assert property (p_no_array) else $error("array change under protection");

  property p_mass_first;
    // the image is already updated when the command shows, so look at the old value
    FLASH_CMD.optb_wr && $past(rp) && !FLASH_CMD.data[READ_PROTECT_POS] |-> mass_done_ff;
  endproperty
  a_mass_first: assert property (p_mass_first) else $error("protection removed without erase");

  property p_clear_both;
    done_ff |=> !run_ff && !latch_en_ff;
  endproperty
  a_clear_both: assert property (p_clear_both) else $error("end of cycle left bits set");

  property p_rc;
    !rst_pin_q_ff && rst_pin_s && pulse_cnt_ff == ENTRY_PULSES_RC |=> comm_ff && INTERNAL_RC_FORCED
      && !EXTERNAL_CLOCK_INPUT_SEL ##1 IN_CIRCUIT_COMM_MODE;
  endproperty
  a_rc: assert property (p_rc) else $error("38-pulse entry wrong");

  property p_pin_reset;
    !rst_pin_s |=> SERIAL_LINK_CLOCK_PIN_OE_N && SERIAL_LINK_CLOCK_PULLUP_EN;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("clock pin not input in reset");

  property p_prog_len;
    go_prog |=> (state_ff == PFAP_PROG) [*8];
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("latch walk cut short");

  c_prog:  cover property (go_prog ##[1:200] done_ff);
  c_erase: cover property (go_erase ##[1:200] done_ff);
  c_mass:  cover property (go_mass ##[1:400] FLASH_CMD.optb_wr);
  c_entry: cover property ($rose(comm_ff) && EXTERNAL_CLOCK_INPUT_SEL);

endmodule

// *** pfap_tool_model.sv ***
// behavioural programming tool: drives the reset pin and the serial link clock
module pfap_tool_model (
  output logic      reset_pin_n,
  output logic      clk_drive,
  output logic      clk_level,
  input  wire logic ext_sel,
  output logic      ext_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reset_pin_n = 1'b1;
    clk_drive   = 1'b0;
    clk_level   = 1'b1;
    ext_clk     = 1'b0;
  end

  // tool supplies the main clock only when the no-option entry was used
  always #100 ext_clk = ext_sel ? ~ext_clk : 1'b0;

  // link clock runs only inside the entry frame; pulled up high between frames
  task automatic enter(input int pulses);
    reset_pin_n = 1'b0;
    #1000;
    clk_drive = 1'b1;
    repeat (pulses) begin
      clk_level = 1'b0;
      #200;
      clk_level = 1'b1;
      #200;
    end
    clk_drive = 1'b0;
    #1000;
    reset_pin_n = 1'b1;
    #1000;
  endtask
endmodule

// *** pfap_tb.sv ***
// self-checking bench for the program flash sequencer
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench import pfap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int pulses; logic [2:0] mode;} pfap_row_t;

  logic REF_CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, MEM_WR = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, MEM_WDATA = 8'h00, REG_RDATA, OPTION_BYTE, v;
  logic [ADDR_W-1:0] MEM_ADDR = 11'h000, first_a, last_a;
  logic [7:0] last_d;
  logic APP_CLK_PIN_OUT_EN = 1'b0, APP_CLK_PIN_LEVEL = 1'b0, clr = 1'b0, ea_first;
  logic FLASH_REFUSED, LNK_O, LNK_OE_N, PULLUP, COMM, EXT_SEL, RC_FORCED, READOUT_BLOCK;
  logic tool_rst_n, tool_drv, tool_lvl, ext_clk, lnk_wire;
  pfap_flash_cmd_t FLASH_CMD;
  int n_wr, n_es, n_ea, n_rf, error_cnt = 0, total_checks = 0;
  pfap_row_t rows[4] = '{'{35, 3'b110}, '{38, 3'b101}, '{37, 3'b000}, '{0, 3'b000}};

  always #25 REF_CLK = ~REF_CLK;

  // device drive wins, then the tool, else the pull-up holds the line high
  assign lnk_wire = !LNK_OE_N ? LNK_O : (tool_drv ? tool_lvl : 1'b1);

  pfap_top u_dut (.REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .FLASH_CMD(FLASH_CMD), .FLASH_REFUSED(FLASH_REFUSED), .OPTION_BYTE(OPTION_BYTE), .RESET_PIN_N(tool_rst_n),
    .SERIAL_LINK_CLOCK_PIN_I(lnk_wire), .SERIAL_LINK_CLOCK_PIN_O(LNK_O), .SERIAL_LINK_CLOCK_PIN_OE_N(LNK_OE_N),
    .SERIAL_LINK_CLOCK_PULLUP_EN(PULLUP), .APP_CLK_PIN_OUT_EN(APP_CLK_PIN_OUT_EN),
    .APP_CLK_PIN_LEVEL(APP_CLK_PIN_LEVEL), .IN_CIRCUIT_COMM_MODE(COMM), .EXTERNAL_CLOCK_INPUT_SEL(EXT_SEL),
    .INTERNAL_RC_FORCED(RC_FORCED), .READOUT_BLOCK(READOUT_BLOCK));

  pfap_tool_model u_tool (.reset_pin_n(tool_rst_n), .clk_drive(tool_drv), .clk_level(tool_lvl),
    .ext_sel(EXT_SEL), .ext_clk(ext_clk));

  always @(posedge REF_CLK) begin
    if (clr) begin
      n_wr <= 0;
      n_es <= 0;
      n_ea <= 0;
      n_rf <= 0;
    end else begin
      if (FLASH_CMD.wr === 1'b1) begin
        n_wr <= n_wr + 1;
        last_a <= FLASH_CMD.addr;
        last_d <= FLASH_CMD.data;
        if (n_wr == 0) first_a <= FLASH_CMD.addr;
      end
      if (FLASH_CMD.erase_sector === 1'b1) n_es <= n_es + 1;
      if (FLASH_CMD.erase_all === 1'b1) n_ea <= n_ea + 1;
      if (FLASH_CMD.optb_wr === 1'b1) ea_first <= (n_ea != 0);
      if (FLASH_REFUSED === 1'b1) n_rf <= n_rf + 1;
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  task automatic mw(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    MEM_ADDR <= a;
    MEM_WDATA <= d;
    MEM_WR <= 1'b1;
    @(posedge REF_CLK);
    MEM_WR <= 1'b0;
  endtask

  task automatic clear_counts();
    @(posedge REF_CLK);
    clr <= 1'b1;
    @(posedge REF_CLK);
    clr <= 1'b0;
  endtask

  task automatic wait_idle();
    int i;
    v = 8'hFF;
    for (i = 0; i < 200 && v[1:0] !== 2'b00; i++) rd(FLASH_CTRL_STAT_OFS, v);
    `CHK("start_latch_clear", 2'b00, v[1:0])
  endtask

  task automatic prog_try(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    clear_counts();
    wr(FLASH_CTRL_STAT_OFS, 8'h02);
    mw(a, d);
    wr(FLASH_CTRL_STAT_OFS, 8'h03);
    wait_idle();
  endtask

  task automatic optb_prog(input logic [7:0] d);
    clear_counts();
    wr(FLASH_CTRL_STAT_OFS, 8'h06);
    mw(11'h000, d);
    wr(FLASH_CTRL_STAT_OFS, 8'h07);
    wait_idle();
  endtask

  task automatic pulse_rst();
    @(posedge REF_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    `CHK("oe_n_in_reset", 1'b1, LNK_OE_N)
    `CHK("pullup_in_reset", 1'b1, PULLUP)
    RST <= 1'b0;
  endtask

  initial begin
    #2_000_000;
    error_cnt++;
    $display("MISMATCH watchdog exp done got hang");
    conclude();
  end

  initial begin
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    rd(FLASH_CTRL_STAT_OFS, v);
    `CHK("ctrl_reset", FLASH_CTRL_STAT_RESET, v)
    `CHK("oe_n_reset", 1'b1, LNK_OE_N)
    `CHK("pullup_reset", 1'b1, PULLUP)
    `CHK("option_reset", OPTION_BYTE_RESET, OPTION_BYTE)
    rd(8'h30, v);
    `CHK("unmapped", 8'h00, v)
    // application drives the pin; resets must take it back
    APP_CLK_PIN_OUT_EN <= 1'b1;
    APP_CLK_PIN_LEVEL <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    `CHK("app_drives", 1'b0, LNK_OE_N)
    `CHK("app_level", 1'b1, LNK_O)
    pulse_rst();
    fork
      u_tool.enter(0);
      begin
        #800;
        `CHK("oe_n_pin_reset", 1'b1, LNK_OE_N)
      end
    join
    APP_CLK_PIN_OUT_EN <= 1'b0;
    foreach (rows[i]) begin
      u_tool.enter(rows[i].pulses);
      `CHK("entry_mode", rows[i].mode, {COMM, EXT_SEL, RC_FORCED})
    end
    wr(FLASH_CTRL_STAT_OFS, 8'h02);
    rd(FLASH_CTRL_STAT_OFS, v);
    `CHK("locked_write", 8'h00, v)
    wr(FLASH_CTRL_STAT_OFS, UNLOCK_KEY_FIRST);
    wr(FLASH_CTRL_STAT_OFS, 8'h00);
    wr(FLASH_CTRL_STAT_OFS, 8'h02);
    rd(FLASH_CTRL_STAT_OFS, v);
    `CHK("bad_second_key", 8'h00, v)
    wr(FLASH_CTRL_STAT_OFS, UNLOCK_KEY_FIRST);
    wr(FLASH_CTRL_STAT_OFS, UNLOCK_KEY_SECOND);
    wr(FLASH_CTRL_STAT_OFS, 8'hFA);
    rd(FLASH_CTRL_STAT_OFS, v);
    `CHK("unlocked_latch", 8'h02, v)
    clear_counts();
    mw(11'h405, 8'hA5);
    mw(11'h41F, 8'h3C);
    wr(FLASH_CTRL_STAT_OFS, 8'h03);
    rd(FLASH_CTRL_STAT_OFS, v);
    `CHK("busy_bits", 8'h03, v)
    wait_idle();
    `CHK("wr_count", 2, n_wr)
    `CHK("wr_first", 11'h405, first_a)
    `CHK("wr_last", 11'h41F, last_a)
    `CHK("wr_data", 8'h3C, last_d)
    clear_counts();
    wr(FLASH_CTRL_STAT_OFS, 8'h01);
    wait_idle();
    `CHK("sector_erase", 1, n_es)
    `CHK("no_mass_erase", 0, n_ea)
    prog_try(11'h010, 8'h5A);
    `CHK("app_sector0_refused", 1, n_rf)
    `CHK("app_sector0_no_wr", 0, n_wr)
    pulse_rst();
    u_tool.enter(38);
    wr(FLASH_CTRL_STAT_OFS, UNLOCK_KEY_FIRST);
    wr(FLASH_CTRL_STAT_OFS, UNLOCK_KEY_SECOND);
    prog_try(11'h010, 8'h5A);
    `CHK("tool_sector0_wr", 1, n_wr)
    `CHK("tool_sector0_addr", 11'h010, last_a)
    optb_prog(8'h01);
    `CHK("read_protect_set", 8'h01, OPTION_BYTE)
    `CHK("readout_block", 1'b1, READOUT_BLOCK)
    prog_try(11'h410, 8'h11);
    `CHK("rp_refused", 1, n_rf)
    `CHK("rp_no_wr", 0, n_wr)
    optb_prog(8'h00);
    `CHK("rp_clear_mass_erase", 1, n_ea)
    `CHK("erase_before_opt", 1'b1, ea_first)
    `CHK("rp_cleared", 8'h00, OPTION_BYTE)
    optb_prog(8'h02);
    `CHK("write_protect_set", 8'h02, OPTION_BYTE)
    `CHK("readout_free", 1'b0, READOUT_BLOCK)
    prog_try(11'h410, 8'h11);
    `CHK("wp_refused", 1, n_rf)
    `CHK("wp_no_wr", 0, n_wr)
    optb_prog(8'h00);
    `CHK("wp_kept", 1'b1, OPTION_BYTE[WRITE_PROTECT_POS])
    conclude();
  end
endmodule
